// ---- design/optical_port_consts.svh ----
// Register indices, field positions, reset values and timing counts of the optical port block.
`ifndef OPTICAL_PORT_CONSTS_SVH
`define OPTICAL_PORT_CONSTS_SVH
`define IDX_PULSE_CTRL      14'h2004
`define IDX_TX_SELECT       14'h2007
`define IDX_PORT_CTRL       14'h2008
`define IDX_PULSE_MAX_WIDTH 14'h2080
`define IDX_PULSE_INTERVAL  14'h2081
`define IDX_STATUS          14'h20F0
`define BIT_PULSE_POL_INV   6
`define BIT_TX_INVERT       0
`define BIT_TX_MOD_EN       1
`define BIT_RX_INVERT       4
`define BIT_RX_TO_GPIO      5
`define RST_PULSE_MAX_WIDTH 8'hFF
`define RST_PULSE_INTERVAL  8'h00
`define RST_DUTY            2'h0
`define RST_TX_SELECT       2'h0
`define WIDTH_NO_LIMIT      8'hFF
`define CLK_PERIOD_NS       100
`define SAMPLE_TIME_NS      397000
`define SAMPLE_CYC          (`SAMPLE_TIME_NS / `CLK_PERIOD_NS)
`define CARRIER_CYC         16
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
`endif

// ---- design/optical_port_pkg.sv ----
// Types shared by the optical port block.
`default_nettype none
package optical_port_pkg;
    typedef enum logic [1:0] {
        TX_FROM_UART     = 2'h0,
        TX_FROM_GPIO     = 2'h1,
        TX_FROM_REAL     = 2'h2,
        TX_FROM_REACTIVE = 2'h3
    } tx_source_t;
    typedef struct packed {
        tx_source_t tx_pin_source_select;
        logic [1:0] tx_modulation_duty;
        logic       tx_invert;
        logic       tx_modulation_enable;
        logic       rx_invert;
        logic       rx_pin_to_gpio;
        logic       pulse_polarity_invert;
        logic [7:0] pulse_max_width;
        logic [7:0] pulse_interval;
    } port_cfg_t;
endpackage
`default_nettype wire

// ---- design/optical_port_pulse_output.sv ----
// Optical port pin routing and energy pulse shaping with an AXI4-Lite register slave.
// Operation
// - The transmit pin source is the UART output, a general output, the real or the reactive pulse.
// - The transmit-invert bit inverts the transmit signal ahead of any modulation.
// - The modulation-enable bit fills the zero intervals of the inverted signal with a carrier.
// - The receive pin feeds the comparator path at 0 and becomes a general input at 1.
// - The receive-invert bit inverts the comparator result and does nothing in general-input use.
// - Each low pulse is cut off after twice the width field plus one time-base ticks.
// - The width time base is the 397 us sample period.
// - A width field of all ones turns limiting off and gives a 50 percent duty output.
// - A zero interval field sends pulses straight out; otherwise they queue and are spaced.
// - Pulse outputs are active low, and active high when the polarity bit is set.
`include "optical_port_consts.svh"
`default_nettype none
module optical_port_pulse_output
    import optical_port_pkg::*;
#(
    parameter int SAMPLE_CYC  = `SAMPLE_CYC,
    parameter int CARRIER_CYC = `CARRIER_CYC
)(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [15:0] awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [15:0] araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    input  wire logic        uart_tx_data,
    input  wire logic        general_io_two_out,
    input  wire logic        general_io_two_oe,
    input  wire logic        real_energy_req,
    input  wire logic        reactive_energy_req,
    input  wire logic        optical_receive_pin,
    output logic             optical_transmit_pin,
    output logic             optical_transmit_pin_oe,
    output logic             uart_rx_data,
    output logic             general_io_one_in,
    output logic             real_energy_pulse,
    output logic             reactive_energy_pulse
);
    localparam int CW = $clog2(CARRIER_CYC);
    localparam int SW = $clog2(SAMPLE_CYC);
    localparam logic [SW-1:0] SAMPLE_LAST = SW'(SAMPLE_CYC - 1);

    port_cfg_t        cfg_reg;
    logic             aw_have_reg;
    logic             w_have_reg;
    logic [13:0]      aw_idx_reg;
    logic [7:0]       w_byte_reg;
    logic             w_lane_reg;
    logic [SW-1:0]    sample_cnt_reg;
    logic             tick;
    logic [CW-1:0]    car_cnt_reg;
    logic [CW-1:0]    car_low;
    logic             carrier;
    logic             tx_src;
    logic             tx_inv;
    logic             tx_mod;
    logic [2:0]       rx_sync_reg;
    logic             rx_stable_reg;
    logic [1:0]       req;
    logic [1:0]       pulse_level;
    logic [1:0]       pulse_pin_reg;
    logic             wr_go;
    logic [13:0]      ar_idx;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Write channels are taken independently, one write outstanding at a time.
    assign awready = !aw_have_reg && !bvalid;
    assign wready  = !w_have_reg && !bvalid;
    assign arready = !rvalid;
    assign wr_go   = aw_have_reg && w_have_reg && !bvalid;
    assign ar_idx  = araddr[15:2];

    // Capture of write address and data until both are present.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            aw_idx_reg  <= 14'h0000;
            w_byte_reg  <= 8'h00;
            w_lane_reg  <= 1'b0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_have_reg <= 1'b1;
                aw_idx_reg  <= awaddr[15:2];
            end
            else if (wr_go)
                aw_have_reg <= 1'b0;
            if (wvalid && wready)
            begin
                w_have_reg <= 1'b1;
                w_byte_reg <= wdata[7:0];
                w_lane_reg <= wstrb[0];
            end
            else if (wr_go)
                w_have_reg <= 1'b0;
        end
    end

    // Write response, with an error for an index outside the map.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp  <= `RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid <= 1'b1;
            case (aw_idx_reg)
                `IDX_PULSE_CTRL, `IDX_TX_SELECT, `IDX_PORT_CTRL,
                `IDX_PULSE_MAX_WIDTH, `IDX_PULSE_INTERVAL, `IDX_STATUS:
                    bresp <= `RESP_OKAY;
                default:
                    bresp <= `RESP_SLVERR;
            endcase
        end
        else if (bready)
            bvalid <= 1'b0;
    end

    // Configuration fields, updated by byte lane 0 of a write.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_reg                      <= '0;
            cfg_reg.tx_pin_source_select <= tx_source_t'(`RST_TX_SELECT);
            cfg_reg.tx_modulation_duty   <= `RST_DUTY;
            cfg_reg.pulse_max_width      <= `RST_PULSE_MAX_WIDTH;
            cfg_reg.pulse_interval       <= `RST_PULSE_INTERVAL;
        end
        else if (wr_go && w_lane_reg)
        begin
            case (aw_idx_reg)
                `IDX_PULSE_CTRL:
                    cfg_reg.pulse_polarity_invert <= w_byte_reg[`BIT_PULSE_POL_INV];
                `IDX_TX_SELECT:
                begin
                    cfg_reg.tx_pin_source_select <= tx_source_t'(w_byte_reg[7:6]);
                    cfg_reg.tx_modulation_duty   <= w_byte_reg[1:0];
                end
                `IDX_PORT_CTRL:
                begin
                    cfg_reg.tx_invert            <= w_byte_reg[`BIT_TX_INVERT];
                    cfg_reg.tx_modulation_enable <= w_byte_reg[`BIT_TX_MOD_EN];
                    cfg_reg.rx_invert            <= w_byte_reg[`BIT_RX_INVERT];
                    cfg_reg.rx_pin_to_gpio       <= w_byte_reg[`BIT_RX_TO_GPIO];
                end
                `IDX_PULSE_MAX_WIDTH:
                    cfg_reg.pulse_max_width <= w_byte_reg;
                `IDX_PULSE_INTERVAL:
                    cfg_reg.pulse_interval <= w_byte_reg;
                default:
                    cfg_reg <= cfg_reg;
            endcase
        end
    end

    // Read channel; the status word shows the receive and transmit pin levels and the two pulse levels.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rresp  <= `RESP_OKAY;
            rdata  <= 32'h0000_0000;
            case (ar_idx)
                `IDX_PULSE_CTRL:
                    rdata[`BIT_PULSE_POL_INV] <= cfg_reg.pulse_polarity_invert;
                `IDX_TX_SELECT:
                    rdata[7:0] <= {cfg_reg.tx_pin_source_select, 4'h0,
                                   cfg_reg.tx_modulation_duty};
                `IDX_PORT_CTRL:
                    rdata[7:0] <= {2'h0, cfg_reg.rx_pin_to_gpio, cfg_reg.rx_invert,
                                   2'h0, cfg_reg.tx_modulation_enable, cfg_reg.tx_invert};
                `IDX_PULSE_MAX_WIDTH:
                    rdata[7:0] <= cfg_reg.pulse_max_width;
                `IDX_PULSE_INTERVAL:
                    rdata[7:0] <= cfg_reg.pulse_interval;
                `IDX_STATUS:
                    rdata[3:0] <= {rx_stable_reg, optical_transmit_pin, pulse_level};
                default:
                    rresp <= `RESP_SLVERR;
            endcase
        end
        else if (rready)
            rvalid <= 1'b0;
    end

    // Sample-period time base for pulse widths and spacing.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || tick)
            sample_cnt_reg <= '0;
        else
            sample_cnt_reg <= sample_cnt_reg + 1'b1;
    end
    assign tick = (sample_cnt_reg == SAMPLE_LAST);

    // Free carrier; its low part is half, quarter, eighth or sixteenth of the period.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            car_cnt_reg <= '0;
        else
            car_cnt_reg <= car_cnt_reg + 1'b1;
    end
    // The shift amount is widened so that duty code 3 gives a shift of four, not zero.
    assign car_low = CW'(CARRIER_CYC >> ({1'b0, cfg_reg.tx_modulation_duty} + 3'd1));
    assign carrier = (car_cnt_reg >= car_low);

    // Transmit path: source, then inversion, then modulation.
    always_comb
    begin
        case (cfg_reg.tx_pin_source_select)
            TX_FROM_UART:     tx_src = uart_tx_data;
            TX_FROM_GPIO:     tx_src = general_io_two_out;
            TX_FROM_REAL:     tx_src = pulse_pin_reg[0];
            TX_FROM_REACTIVE: tx_src = pulse_pin_reg[1];
            default:          tx_src = uart_tx_data;
        endcase
    end
    assign tx_inv = tx_src ^ cfg_reg.tx_invert;
    assign tx_mod = cfg_reg.tx_modulation_enable ? (tx_inv | carrier) : tx_inv;

    // Transmit pin register; the enable follows the general output enable in I/O use.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            optical_transmit_pin    <= 1'b0;
            optical_transmit_pin_oe <= 1'b1;
        end
        else
        begin
            optical_transmit_pin    <= tx_mod;
            optical_transmit_pin_oe <= (cfg_reg.tx_pin_source_select != TX_FROM_GPIO)
                                       || general_io_two_oe;
        end
    end

    // Receive pin synchroniser; a level counts once stages two and three agree.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_sync_reg   <= 3'h7;
            rx_stable_reg <= 1'b1;
        end
        else
        begin
            rx_sync_reg <= {rx_sync_reg[1:0], optical_receive_pin};
            if (rx_sync_reg[1] == rx_sync_reg[2])
                rx_stable_reg <= rx_sync_reg[2];
        end
    end

    // Receive routing to the UART or to the general input.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            uart_rx_data      <= 1'b1;
            general_io_one_in <= 1'b0;
        end
        else
        begin
            uart_rx_data      <= cfg_reg.rx_pin_to_gpio ? 1'b1 :
                                 (rx_stable_reg ^ cfg_reg.rx_invert);
            general_io_one_in <= cfg_reg.rx_pin_to_gpio ? rx_stable_reg : 1'b0;
        end
    end

    assign req = {reactive_energy_req, real_energy_req};

    // One pulse shaper for the real and one for the reactive channel.
    for (genvar i = 0; i < 2; i++)
    begin : g_pulse
        logic [3:0] pend_reg;
        logic [7:0] gap_reg;
        logic [8:0] wcnt_reg;
        logic       active_reg;
        logic       toggle_reg;
        logic       fire;
        logic       queued;
        logic       no_limit;

        assign queued   = (cfg_reg.pulse_interval != 8'h00);
        assign no_limit = (cfg_reg.pulse_max_width == `WIDTH_NO_LIMIT);
        assign fire     = queued ? ((pend_reg != 4'h0) && (gap_reg == 8'h00) && !active_reg)
                                 : req[i];

        // Queue of pending pulses and spacing counter; a request and a release in one cycle leave the count unchanged.
        always_ff @(posedge aclk)
        begin
            if (!aresetn || !queued)
            begin
                pend_reg <= 4'h0;
                gap_reg  <= 8'h00;
            end
            else
            begin
                if (req[i] && !fire && pend_reg != 4'hF)
                    pend_reg <= pend_reg + 4'h1;
                else if (fire && !req[i])
                    pend_reg <= pend_reg - 4'h1;
                if (fire)
                    gap_reg <= cfg_reg.pulse_interval;
                else if (tick && gap_reg != 8'h00)
                    gap_reg <= gap_reg - 8'h01;
            end
        end

        // Width-limited pulse, or a level that toggles per pulse when limiting is off.
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                active_reg <= 1'b0;
                toggle_reg <= 1'b0;
                wcnt_reg   <= 9'h000;
            end
            else if (fire && no_limit)
            begin
                toggle_reg <= !toggle_reg;
                active_reg <= 1'b0;
            end
            else if (fire)
            begin
                active_reg <= 1'b1;
                wcnt_reg   <= 9'h000;
            end
            else if (active_reg && tick)
            begin
                wcnt_reg <= wcnt_reg + 9'h001;
                if (wcnt_reg == {cfg_reg.pulse_max_width, 1'b0})
                    active_reg <= 1'b0;
            end
        end

        assign pulse_level[i] = no_limit ? toggle_reg : active_reg;

        // Pin level: low while active, unless the polarity is inverted.
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
                pulse_pin_reg[i] <= 1'b1;
            else
                pulse_pin_reg[i] <= pulse_level[i] ^ !cfg_reg.pulse_polarity_invert;
        end

        AST_PULSE_DIRECT: assert property (!queued && req[i] && !no_limit |=> active_reg)
            else $error("direct pulse not started");
        AST_PULSE_WIDTH: assert property (active_reg && !no_limit |->
                wcnt_reg <= {cfg_reg.pulse_max_width, 1'b0})
            else $error("pulse wider than limit");
        AST_PULSE_POLARITY: assert property (##1 pulse_pin_reg[i] ==
                ($past(pulse_level[i]) ^ !$past(cfg_reg.pulse_polarity_invert)))
            else $error("pulse polarity wrong");
        AST_PULSE_TOGGLE: assert property (fire && no_limit |=> toggle_reg != $past(toggle_reg))
            else $error("half duty toggle missed");
    end

    assign real_energy_pulse     = pulse_pin_reg[0];
    assign reactive_energy_pulse = pulse_pin_reg[1];

    sequence tx_plain_s;
        !cfg_reg.tx_modulation_enable && !cfg_reg.tx_invert;
    endsequence
    sequence tx_zero_mod_s;
        cfg_reg.tx_modulation_enable && !tx_inv;
    endsequence

    AST_TX_SOURCE: assert property (tx_plain_s ##0
            (cfg_reg.tx_pin_source_select == TX_FROM_REAL) |=>
            optical_transmit_pin == $past(pulse_pin_reg[0]))
        else $error("transmit source wrong");
    AST_TX_INVERT: assert property (!cfg_reg.tx_modulation_enable |=>
            optical_transmit_pin == ($past(tx_src) ^ $past(cfg_reg.tx_invert)))
        else $error("transmit inversion wrong");
    AST_TX_MODULATE: assert property (tx_zero_mod_s |=> optical_transmit_pin == $past(carrier))
        else $error("modulation missing");
    AST_DUTY_LOW: assert property (car_cnt_reg == '0 |-> !carrier)
        else $error("carrier not low at start");
    AST_DUTY_HIGH: assert property (car_cnt_reg >= CW'(CARRIER_CYC / 2) |-> carrier)
        else $error("carrier low too long");
    AST_RX_GPIO: assert property (cfg_reg.rx_pin_to_gpio |=> uart_rx_data)
        else $error("receive not parked in gpio use");
    AST_RX_INVERT: assert property (!cfg_reg.rx_pin_to_gpio |=>
            uart_rx_data == ($past(rx_stable_reg) ^ $past(cfg_reg.rx_invert)))
        else $error("receive inversion wrong");
    AST_TICK_PERIOD: assert property (tick |=> !tick [*2])
        else $error("time base too fast");
endmodule
`default_nettype wire

// ---- bench/optical_link_model.sv ----
// Behavioural optical head that shines light onto the receive comparator of the port.
`default_nettype none
module optical_link_model (
    input  wire logic light_on,
    output logic      optical_receive_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // The photodiode level follows the light with its own delay, unrelated to the clock edge.
    assign #13 optical_receive_pin = light_on;
endmodule
`default_nettype wire

// ---- bench/optical_port_pulse_output_tb.sv ----
// Self-checking testbench for the optical port pin routing and pulse shaping block.
`include "optical_port_consts.svh"
`default_nettype none
module optical_port_pulse_output_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, uart_tx, io2_out, io2_oe, light;
    logic        real_req, react_req, rx_pin, tx_pin, tx_oe, rx_data, io1_in, real_p, react_p;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    int          num_errors, checked, lows, f;

    optical_port_pulse_output #(.SAMPLE_CYC(8), .CARRIER_CYC(16)) DUT (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .uart_tx_data(uart_tx), .general_io_two_out(io2_out),
        .general_io_two_oe(io2_oe), .real_energy_req(real_req),
        .reactive_energy_req(react_req), .optical_receive_pin(rx_pin),
        .optical_transmit_pin(tx_pin), .optical_transmit_pin_oe(tx_oe),
        .uart_rx_data(rx_data), .general_io_one_in(io1_in), .real_energy_pulse(real_p),
        .reactive_energy_pulse(react_p)
    );
    optical_link_model head (.light_on(light), .optical_receive_pin(rx_pin));

    // The clock runs at 10 MHz.
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // Compares one observed value with its expectation and counts the outcome.
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Write cycle: address and data offered together, each dropped once taken.
    task wr(input logic [13:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= {idx, 2'b00};
        wdata <= {24'h00_0000, d};
        bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) begin num_errors++; report_and_stop(); end
        check("bresp", bresp, er);
        bready <= 1'b0;
    endtask

    // Read cycle: the data and response are taken at the edge that shows rvalid.
    task rd(input logic [13:0] idx, input logic [7:0] ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= {idx, 2'b00};
        rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) begin num_errors++; report_and_stop(); end
        check("rdata", rdata, {24'h00_0000, ed});
        check("rresp", rresp, er);
        rready <= 1'b0;
    endtask

    // Counts low cycles of the transmit pin (sel 0) or the real pulse (sel 1).
    task cnt_low(input int sel, input int n, output int c);
        c = 0;
        repeat (n)
        begin
            @(posedge aclk);
            if ((sel == 0) ? !tx_pin : !real_p) c++;
        end
    endtask

    // Raises the real energy request for len cycles and counts pulse starts.
    task burst(input int len, output int c);
        logic prev;
        @(posedge aclk);
        real_req <= 1'b1;
        tick(len);
        real_req <= 1'b0;
        prev = real_p;
        c = 0;
        repeat (150)
        begin
            @(posedge aclk);
            if (prev && !real_p) c++;
            prev = real_p;
        end
    endtask

    // Raises one energy request (ch 0 real, 1 reactive) for one cycle, then waits three cycles.
    task pulse_once(input int ch);
        @(posedge aclk);
        if (ch == 0)
            real_req <= 1'b1;
        else
            react_req <= 1'b1;
        @(posedge aclk);
        {react_req, real_req} <= 2'b00;
        tick(3);
    endtask

    task t_regs();
        rd(`IDX_PULSE_MAX_WIDTH, 8'hFF, `RESP_OKAY);
        rd(`IDX_PULSE_INTERVAL, 8'h00, `RESP_OKAY);
        rd(`IDX_TX_SELECT, 8'h00, `RESP_OKAY);
        rd(`IDX_PORT_CTRL, 8'h00, `RESP_OKAY);
        rd(`IDX_PULSE_CTRL, 8'h00, `RESP_OKAY);
        rd(14'h0100, 8'h00, `RESP_SLVERR);
        wr(14'h0100, 8'h5A, `RESP_SLVERR);
        wr(`IDX_PULSE_INTERVAL, 8'hA5, `RESP_OKAY);
        rd(`IDX_PULSE_INTERVAL, 8'hA5, `RESP_OKAY);
        wstrb <= 4'h0;
        wr(`IDX_PULSE_INTERVAL, 8'h33, `RESP_OKAY);
        wstrb <= 4'h1;
        rd(`IDX_PULSE_INTERVAL, 8'hA5, `RESP_OKAY);
        wr(`IDX_PULSE_INTERVAL, 8'h00, `RESP_OKAY);
        $display("test registers done");
    endtask

    task t_route();
        uart_tx <= 1'b0;
        tick(3);
        check("tx_uart", tx_pin, 1'b0);
        wr(`IDX_PORT_CTRL, 8'h01, `RESP_OKAY);
        tick(2);
        check("tx_inv", tx_pin, 1'b1);
        wr(`IDX_PORT_CTRL, 8'h00, `RESP_OKAY);
        io2_out <= 1'b1;
        wr(`IDX_TX_SELECT, 8'h40, `RESP_OKAY);
        tick(3);
        check("tx_gpio", {tx_oe, tx_pin}, 2'b11);
        io2_oe <= 1'b0;
        tick(3);
        check("tx_gpio_oe", tx_oe, 1'b0);
        wr(`IDX_TX_SELECT, 8'h80, `RESP_OKAY);
        tick(3);
        check("tx_real", tx_pin, 1'b1);
        wr(`IDX_TX_SELECT, 8'hC0, `RESP_OKAY);
        pulse_once(1);
        check("react_toggle", {react_p, tx_pin}, 2'b00);
        $display("test routing done");
    endtask

    task t_mod();
        wr(`IDX_TX_SELECT, 8'h00, `RESP_OKAY);
        uart_tx <= 1'b1;
        wr(`IDX_PORT_CTRL, 8'h02, `RESP_OKAY);
        tick(3);
        cnt_low(0, 16, lows);
        check("mod_high", lows, 0);
        wr(`IDX_PORT_CTRL, 8'h03, `RESP_OKAY);
        for (int d = 0; d < 4; d++)
        begin
            wr(`IDX_TX_SELECT, d[7:0], `RESP_OKAY);
            tick(3);
            cnt_low(0, 16, lows);
            check("mod_lows", lows, 8 >> d);
        end
        wr(`IDX_PORT_CTRL, 8'h00, `RESP_OKAY);
        $display("test modulation done");
    endtask

    task t_rx();
        light <= 1'b0;
        tick(8);
        check("rx_cmp", {rx_data, io1_in}, 2'b00);
        wr(`IDX_PORT_CTRL, 8'h10, `RESP_OKAY);
        tick(3);
        check("rx_inv", rx_data, 1'b1);
        wr(`IDX_PORT_CTRL, 8'h30, `RESP_OKAY);
        tick(3);
        check("rx_gpio_lo", {rx_data, io1_in}, 2'b10);
        light <= 1'b1;
        tick(8);
        check("rx_gpio_hi", {rx_data, io1_in}, 2'b11);
        rd(`IDX_STATUS, 8'h0E, `RESP_OKAY);
        wr(`IDX_PORT_CTRL, 8'h00, `RESP_OKAY);
        $display("test receive done");
    endtask

    task t_pulse();
        wr(`IDX_PULSE_MAX_WIDTH, 8'h02, `RESP_OKAY);
        pulse_once(0);
        check("pulse_start", real_p, 1'b0);
        cnt_low(1, 60, lows);
        check("pulse_width", (lows + 2 >= 33) && (lows + 2 <= 40), 1'b1);
        wr(`IDX_PULSE_CTRL, 8'h40, `RESP_OKAY);
        tick(3);
        check("pol_idle", real_p, 1'b0);
        pulse_once(0);
        check("pol_pulses", real_p, 1'b1);
        tick(45);
        check("pol_end", real_p, 1'b0);
        wr(`IDX_PULSE_CTRL, 8'h00, `RESP_OKAY);
        wr(`IDX_PULSE_MAX_WIDTH, 8'h00, `RESP_OKAY);
        burst(2, f);
        check("direct_restart", f, 1);
        wr(`IDX_PULSE_INTERVAL, 8'h02, `RESP_OKAY);
        burst(2, f);
        check("queued_pulses", f, 2);
        $display("test pulses done");
    endtask

    // Main sequence: reset for four cycles, then every scenario in turn.
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, real_req, react_req} = '0;
        {uart_tx, io2_out} = 2'b00;
        {io2_oe, light} = 2'b11;
        awaddr = 16'h0000;
        araddr = 16'h0000;
        wdata = 32'h0000_0000;
        wstrb = 4'h1;
        num_errors = 0;
        checked = 0;
        tick(4);
        aresetn <= 1'b1;
        t_regs();
        t_route();
        t_mod();
        t_rx();
        t_pulse();
        report_and_stop();
    end
endmodule
`default_nettype wire
